// >>> hdl/pbmux_port_b.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Each pin feeds pin change sources 8..15, bit 7 not while reset pin
// - Timer outputs need pin direction set
// - Channel A even bits, B odd, steered
// - Reset fuse programmed: bit 7 plain I/O
// - Reset fuse unprogrammed: bit 7 resets
// - Reset pin reads direction, data, input 0
// - Debug fuse, lock bits clear: reset pin open-drain with pull-up
// - Bit 6 sources external interrupt zero
// - Clock fuse drives divided clock bit 5
// - Clock output continues during reset
// - Oscillator pin two blocks bit 5 I/O
// - Bit 4 oscillator input except RC
// - Clock pin bit 4 reads all 0
// - Bit 2 is shifter clock input
// - Bit 0 data in or two-wire data
// - Three-wire data out replaces bit 1 data
// - Bit 1 pull-up kept when input
// - Two-wire bit 2 output forced low
module pbmux_port_b #(
  parameter int WIDTH = pbmux_pkg::PB_WIDTH  // Port width
) (
  input  wire logic             ref_clk,     // System clock
  input  wire logic             sys_rst,     // Sync reset, high
  input  wire logic             clk_en,      // Freezes state when low
  input  wire logic [WIDTH-1:0] port_dir,    // Direction bits
  input  wire logic [WIDTH-1:0] port_data,   // Data bits
  input  wire logic             pullup_off,  // Global pull-up disable
  input  wire logic [WIDTH-1:0] pin_in,      // Pad input levels
  input  wire logic [7:0]       timer1_control_d, // Steering bits
  input  wire logic             timer1_chan_a,    // Compare output A
  input  wire logic             timer1_chan_b,    // Compare output B
  input  wire logic             reset_pin_disable_fuse, // Programmed high
  input  wire logic             debug_line_enable_fuse, // Programmed high
  input  wire logic             lock_bits_programmed,   // Lock active
  input  wire logic             debug_line_drive_low,   // Debug pulls low
  input  wire logic             clock_output_fuse,      // Programmed high
  input  wire logic             divided_clock_out,      // Divided clock
  input  wire logic             oscillator_pin_two_used, // Crystal on b5
  input  wire logic             oscillator_pin_one_used, // Not RC clock
  input  wire logic             shifter_three_wire_active, // 3-wire mode
  input  wire logic             shifter_two_wire_active,   // 2-wire mode
  input  wire logic             shifter_pin_position_select, // 1=alt pos
  input  wire logic             shifter_data_out,     // Shifter out bit
  input  wire logic             shifter_scl_hold,     // Clock stretch
  output logic [WIDTH-1:0]      pin_out,     // Pad output value
  output logic [WIDTH-1:0]      pin_oe,      // Pad drive enable
  output logic [WIDTH-1:0]      pin_pullup,  // Pad pull-up enable
  output logic [WIDTH-1:0]      read_dir,    // Direction read-back
  output logic [WIDTH-1:0]      read_data,   // Data read-back
  output logic [WIDTH-1:0]      read_pin,    // Input read-back
  output logic [15:0]           pin_change_src, // Sources 8..15 upper
  output logic                  external_irq_zero, // Interrupt input
  output logic                  shifter_clock_in,  // Shifter clock
  output logic                  shifter_serial_in, // Shifter data in
  output logic                  reset_request,     // Pin reset level
  output logic                  debug_line_in      // Debug line level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] pin_out;       // Registered pad value
    logic [WIDTH-1:0] pin_oe;        // Registered pad enable
    logic [WIDTH-1:0] pin_pullup;    // Registered pull-up
    logic [WIDTH-1:0] read_dir;      // Registered dir read-back
    logic [WIDTH-1:0] read_data;     // Registered data read-back
    logic [WIDTH-1:0] read_pin;      // Registered pin read-back
    logic [15:0]      pcint;         // Pin change sources
    logic             irq0;          // External interrupt zero
    logic             sck;           // Shifter clock in
    logic             sdi;           // Shifter data in
    logic             rst_req;       // Reset request
    logic             dbg_in;        // Debug line in
  } pbmux_state_t;

  pbmux_state_t state;               // Current state
  pbmux_state_t next_state;          // Next state

  localparam logic BIT_ZERO = pbmux_pkg::BIT_RST;  // Cleared bit
  localparam logic BIT_ONE  = pbmux_pkg::BIT_ONE;  // Set bit

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic reset_pin_mode;              // Bit 7 owned by reset
  logic debug_mode;                  // Bit 7 is debug line
  logic b4_clock;                    // Bit 4 is clock pin
  logic b5_clock;                    // Bit 5 owned by clock logic
  logic two_wire_dflt;               // Two-wire at default position
  logic three_wire_dflt;             // Three-wire at default position
  logic [WIDTH-1:0] steer;           // Per-pin timer steering
  logic [WIDTH-1:0] timer_val;       // Per-pin timer value

  assign reset_pin_mode = !reset_pin_disable_fuse;
  assign debug_mode = debug_line_enable_fuse && !lock_bits_programmed
                      && reset_pin_mode;
  assign b4_clock = oscillator_pin_one_used;
  assign b5_clock = oscillator_pin_two_used;
  assign two_wire_dflt = shifter_two_wire_active
                         && !shifter_pin_position_select;
  assign three_wire_dflt = shifter_three_wire_active
                           && !shifter_pin_position_select;

  // Even pins take channel A steering, odd pins channel B
  always_comb
  begin
    steer = '0;
    timer_val = '0;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (i % 2 == 0)
      begin
        steer[i] = timer1_control_d[pbmux_pkg::STEER_A_BASE + i / 2];
        timer_val[i] = timer1_chan_a;
      end
      else
      begin
        steer[i] = timer1_control_d[pbmux_pkg::STEER_B_BASE + i / 2];
        timer_val[i] = timer1_chan_b;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    if (clk_en)
    begin
      // Plain port behaviour by default
      for (int i = 0; i < WIDTH; i++)
      begin
        next_state.pin_oe[i] = port_dir[i];
        next_state.pin_out[i] = port_data[i];
        next_state.pin_pullup[i] = !port_dir[i] && port_data[i]
                                   && !pullup_off;
        // Timer output only on output pins
        if (steer[i] && port_dir[i])
        begin
          next_state.pin_out[i] = timer_val[i];
        end
      end
      next_state.read_dir = port_dir;
      next_state.read_data = port_data;
      next_state.read_pin = pin_in;

      // Bit 1: three-wire data out replaces data value
      if (three_wire_dflt)
      begin
        next_state.pin_out[pbmux_pkg::BIT_DOUT] = shifter_data_out;
        // Pull-up left as the plain rule computed it
        next_state.pin_pullup[pbmux_pkg::BIT_DOUT] =
          !port_dir[pbmux_pkg::BIT_DOUT] && port_data[pbmux_pkg::BIT_DOUT]
          && !pullup_off;
      end

      // Bit 2: two-wire clock, held low when driven
      if (two_wire_dflt)
      begin
        next_state.pin_oe[pbmux_pkg::BIT_SCK] =
          (shifter_scl_hold || port_data[pbmux_pkg::BIT_SCK])
          && port_dir[pbmux_pkg::BIT_SCK];
        if (port_dir[pbmux_pkg::BIT_SCK])
        begin
          next_state.pin_out[pbmux_pkg::BIT_SCK] = BIT_ZERO;
        end
      end

      // Bit 0: two-wire data, open-drain style
      if (two_wire_dflt)
      begin
        next_state.pin_oe[pbmux_pkg::BIT_SDA] =
          (!shifter_data_out || port_data[pbmux_pkg::BIT_SDA])
          && port_dir[pbmux_pkg::BIT_SDA];
        if (port_dir[pbmux_pkg::BIT_SDA])
        begin
          next_state.pin_out[pbmux_pkg::BIT_SDA] = BIT_ZERO;
        end
      end

      // Bit 4: clock pin, no I/O, reads zero
      if (b4_clock)
      begin
        next_state.pin_oe[pbmux_pkg::BIT_OSCILLATOR_PIN_ONE] = BIT_ZERO;
        next_state.pin_pullup[pbmux_pkg::BIT_OSCILLATOR_PIN_ONE] = BIT_ZERO;
        next_state.read_dir[pbmux_pkg::BIT_OSCILLATOR_PIN_ONE] = BIT_ZERO;
        next_state.read_data[pbmux_pkg::BIT_OSCILLATOR_PIN_ONE] = BIT_ZERO;
        next_state.read_pin[pbmux_pkg::BIT_OSCILLATOR_PIN_ONE] = BIT_ZERO;
      end

      // Bit 5: crystal pin or divided clock out
      if (b5_clock)
      begin
        next_state.pin_oe[pbmux_pkg::BIT_DIVIDED_CLOCK_OUT] = BIT_ZERO;
        next_state.pin_pullup[pbmux_pkg::BIT_DIVIDED_CLOCK_OUT] = BIT_ZERO;
      end
      else if (clock_output_fuse)
      begin
        next_state.pin_oe[pbmux_pkg::BIT_DIVIDED_CLOCK_OUT] = BIT_ONE;
        next_state.pin_out[pbmux_pkg::BIT_DIVIDED_CLOCK_OUT] = divided_clock_out;
        next_state.pin_pullup[pbmux_pkg::BIT_DIVIDED_CLOCK_OUT] = BIT_ZERO;
      end

      // Bit 7: reset or debug line
      if (reset_pin_mode)
      begin
        next_state.pin_oe[pbmux_pkg::BIT_RESET] =
          debug_mode && debug_line_drive_low;
        next_state.pin_out[pbmux_pkg::BIT_RESET] = BIT_ZERO;
        next_state.pin_pullup[pbmux_pkg::BIT_RESET] = BIT_ONE;
        next_state.read_dir[pbmux_pkg::BIT_RESET] = BIT_ZERO;
        next_state.read_data[pbmux_pkg::BIT_RESET] = BIT_ZERO;
        next_state.read_pin[pbmux_pkg::BIT_RESET] = BIT_ZERO;
      end

      // Inputs to other blocks
      next_state.pcint = pbmux_pkg::PC_RST;
      next_state.pcint[pbmux_pkg::PCINT_BASE +: WIDTH] = pin_in;
      if (reset_pin_mode)
      begin
        next_state.pcint[pbmux_pkg::PCINT_BASE + pbmux_pkg::BIT_RESET] =
          BIT_ZERO;
      end
      next_state.irq0 = pin_in[pbmux_pkg::BIT_IRQ0];
      next_state.sck = pin_in[pbmux_pkg::BIT_SCK];
      next_state.sdi = pin_in[pbmux_pkg::BIT_SDA];
      next_state.rst_req = reset_pin_mode && !debug_mode
                           && !pin_in[pbmux_pkg::BIT_RESET];
      next_state.dbg_in = debug_mode && pin_in[pbmux_pkg::BIT_RESET];
    end
  end

  // ----------------------------------------------------------------
  // Register; clock output keeps running through reset
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state <= '0;
      if (clock_output_fuse && !oscillator_pin_two_used)
      begin
        state.pin_oe[pbmux_pkg::BIT_DIVIDED_CLOCK_OUT] <= BIT_ONE;
        state.pin_out[pbmux_pkg::BIT_DIVIDED_CLOCK_OUT] <= divided_clock_out;
      end
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pin_out = state.pin_out;
  assign pin_oe = state.pin_oe;
  assign pin_pullup = state.pin_pullup;
  assign read_dir = state.read_dir;
  assign read_data = state.read_data;
  assign read_pin = state.read_pin;
  assign pin_change_src = state.pcint;
  assign external_irq_zero = state.irq0;
  assign shifter_clock_in = state.sck;
  assign shifter_serial_in = state.sdi;
  assign reset_request = state.rst_req;
  assign debug_line_in = state.dbg_in;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_divided_clock_out_sel;
    clock_output_fuse && !oscillator_pin_two_used && clk_en;
  endsequence

  a_timer_needs_dir: assert property (
    clk_en && !port_dir[3] |=> !pin_oe[3])
    else $error("Timer drove pin 3 while input");
  a_timer_steer_b3: assert property (
    clk_en && port_dir[3] && timer1_control_d[5] |=>
    pin_out[3] == $past(timer1_chan_b))
    else $error("Channel B V not on pin 3");
  a_pcint_map: assert property (
    clk_en |=> pin_change_src[11:8] == $past(pin_in[3:0]))
    else $error("Pin change sources misnumbered");
  a_reset_reads_zero: assert property (
    clk_en && !reset_pin_disable_fuse |=>
    !read_dir[7] && !read_data[7] && !read_pin[7])
    else $error("Reset pin read-back not zero");
  a_plain_bit7: assert property (
    clk_en && reset_pin_disable_fuse && !timer1_control_d[7] |=>
    pin_oe[7] == $past(port_dir[7]) && !reset_request)
    else $error("Bit 7 not plain I/O");
  a_divided_clock_out_drive: assert property (
    s_divided_clock_out_sel |=> pin_oe[5] && pin_out[5] == $past(divided_clock_out))
    else $error("Divided clock missing on bit 5");
  a_clock_reads: assert property (
    clk_en && oscillator_pin_one_used |=>
    !read_dir[4] && !read_data[4] && !read_pin[4])
    else $error("Clock pin read-back not zero");
  a_irq0_path: assert property (
    clk_en |=> external_irq_zero == $past(pin_in[6]))
    else $error("Interrupt zero not from bit 6");
  a_scl_low: assert property (
    clk_en && shifter_two_wire_active && !shifter_pin_position_select
    && port_dir[2] |=> !pin_out[2])
    else $error("Two-wire clock not forced low");
  a_dout_path: assert property (
    clk_en && shifter_three_wire_active && !shifter_pin_position_select
    |=> pin_out[1] == $past(shifter_data_out)
    && pin_oe[1] == $past(port_dir[1]))
    else $error("Shifter data out not on bit 1");
  a_reset_level: assert property (
    clk_en && !reset_pin_disable_fuse && !debug_line_enable_fuse |=>
    reset_request == !$past(pin_in[7]))
    else $error("Reset request not from bit 7 level");
  a_debug_drive: assert property (
    clk_en && !reset_pin_disable_fuse && debug_line_enable_fuse
    && !lock_bits_programmed |=>
    pin_oe[7] == $past(debug_line_drive_low) && !pin_out[7]
    && pin_pullup[7])
    else $error("Debug line not open-drain with pull-up");
  a_crystal_b5: assert property (
    clk_en && oscillator_pin_two_used |=> !pin_oe[5] && !pin_pullup[5])
    else $error("Bit 5 driven while crystal pin");
  // Reset itself must not silence the clock output
  a_divided_clock_out_in_reset: assert property (
    disable iff (1'b0)
    sys_rst && clock_output_fuse && !oscillator_pin_two_used |=>
    pin_oe[5] && pin_out[5] == $past(divided_clock_out))
    else $error("Divided clock lost during reset");
  a_sda_low: assert property (
    clk_en && shifter_two_wire_active && !shifter_pin_position_select
    && port_dir[0] |=> !pin_out[0])
    else $error("Two-wire data not driven low");
  a_dout_pullup: assert property (
    clk_en && shifter_three_wire_active && !shifter_pin_position_select
    && !port_dir[1] && port_data[1] && !pullup_off |=> pin_pullup[1])
    else $error("Bit 1 pull-up lost in three-wire mode");

endmodule

// >>> hdl/pbmux_pkg.sv
package pbmux_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int PB_WIDTH = 8;          // Pins on port B

  // ----------------------------------------------------------------
  // Pin positions of alternate functions
  // ----------------------------------------------------------------
  localparam int BIT_SDA      = 0;      // Shifter data in / two-wire data
  localparam int BIT_DOUT     = 1;      // Shifter three-wire data out
  localparam int BIT_SCK      = 2;      // Shifter clock
  localparam int BIT_OSCILLATOR_PIN_ONE    = 4;      // Oscillator pin one / clock in
  localparam int BIT_DIVIDED_CLOCK_OUT     = 5;      // Oscillator pin two / clock out
  localparam int BIT_IRQ0     = 6;      // External interrupt zero
  localparam int BIT_RESET    = 7;      // Reset / debug line

  // ----------------------------------------------------------------
  // Pin change numbering and timer steering layout
  // ----------------------------------------------------------------
  localparam int PCINT_BASE   = 8;      // First pin change source of port
  localparam int PCINT_WIDTH  = 16;     // Pin change sources seen by block
  localparam int STEER_WIDTH  = 8;      // Steering bits in control reg D
  localparam int STEER_A_BASE = 0;      // Channel A bits U..X
  localparam int STEER_B_BASE = 4;      // Channel B bits U..X

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PB_RST  = 8'h00; // Port bus reset value
  localparam logic [15:0] PC_RST = 16'h0000; // Pin change reset value
  localparam logic       BIT_RST = 1'b0;  // Single bit reset value
  localparam logic       BIT_ONE = 1'b1;  // Single bit set value

endpackage

// >>> dv/pbmux_pad_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Outside circuit on the port B pads
// ----------------------------------------------------------------
module pbmux_pad_model (
  input  wire logic       ref_clk,    // System clock
  input  wire logic [7:0] pin_out,    // Device drive value
  input  wire logic [7:0] pin_oe,     // Device drive enable
  input  wire logic [7:0] pin_pullup, // Device pull-up enable
  input  wire logic [7:0] ext_en,     // Outside driver enable
  input  wire logic [7:0] ext_val,    // Outside driver value
  output logic      [7:0] pin_in      // Resolved pad level
);
  logic float_q;                      // Level of an undriven pad

  // Undriven pads wander so a stale level never passes
  always_ff @(posedge ref_clk)
  begin
    float_q <= (float_q === 1'b1) ? 1'b0 : 1'b1;
  end

  // Device first, then outside driver, then pull-up, else float
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_q;
    end
  end
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, ex, sn) \
  begin \
    n_checks++; \
    if ((sn) !== (ex)) \
    begin \
      bad_count++; \
      $display("unexpected %s expected %h seen %h", nm, ex, sn); \
    end \
  end
// ----------------------------------------------------------------
// Port B steering bench
// ----------------------------------------------------------------
module tb_top;
  logic clk, rst, en, puoff, cha, chb, rfuse, dfuse, lock, dlow; // Inputs
  logic cfuse, dclk, osc2, osc1, w3, w2, pos, sdo, hold;         // Inputs
  logic [7:0] dir, data, steer, ext_en, ext_val;   // Port bits, far side
  logic [7:0] pin_in, pin_out, pin_oe, pin_pu;     // Pad controls
  logic [7:0] r_dir, r_data, r_pin;                // Read-back
  logic [15:0] pcs;                                // Pin change sources
  logic irq0, sck, sdi, rreq, dbg;                 // Routed inputs
  int bad_count = 0;                               // Mismatches
  int n_checks = 0;                                // Comparisons

  pbmux_port_b dut_u (.ref_clk(clk), .sys_rst(rst), .clk_en(en),
    .port_dir(dir), .port_data(data), .pullup_off(puoff), .pin_in(pin_in),
    .timer1_control_d(steer), .timer1_chan_a(cha), .timer1_chan_b(chb),
    .reset_pin_disable_fuse(rfuse), .debug_line_enable_fuse(dfuse),
    .lock_bits_programmed(lock), .debug_line_drive_low(dlow),
    .clock_output_fuse(cfuse), .divided_clock_out(dclk),
    .oscillator_pin_two_used(osc2), .oscillator_pin_one_used(osc1),
    .shifter_three_wire_active(w3), .shifter_two_wire_active(w2),
    .shifter_pin_position_select(pos), .shifter_data_out(sdo),
    .shifter_scl_hold(hold), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pu), .read_dir(r_dir), .read_data(r_data),
    .read_pin(r_pin), .pin_change_src(pcs), .external_irq_zero(irq0),
    .shifter_clock_in(sck), .shifter_serial_in(sdi),
    .reset_request(rreq), .debug_line_in(dbg));

  pbmux_pad_model pad_u (.ref_clk(clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pu), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Baseline: bit 7 plain, no clock pins, shifter off
  task automatic idle;
    {en, rfuse, ext_en} = {1'b1, 1'b1, 8'hff};
    {dir, data, steer, ext_val, puoff, cha, chb} = '0;
    {dfuse, lock, dlow, cfuse, dclk, osc2, osc1} = '0;
    {w3, w2, pos, sdo, hold} = '0;
  endtask

  // Outputs lag one edge, pad read-back one more
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Verdict and end of run
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset held six cycles with clock output fuse set
  task automatic t_reset;
    idle();
    {rst, cfuse, dclk, dir} = {1'b1, 1'b1, 1'b1, 8'hff};
    repeat (6) @(posedge clk);
    #1;
    `CHK("pin_oe", 8'h20, pin_oe)
    `CHK("pin_out", 8'h20, pin_out)
    `CHK("read_dir", 8'h00, r_dir)
    rst = 1'b0;
  endtask

  // Pad levels reach change sources and routed inputs
  task automatic t_inputs(input logic [7:0] v);
    idle();
    ext_val = v;
    settle();
    `CHK("pin_change_src", {v, 8'h00}, pcs)
    `CHK("external_irq_zero", v[6], irq0)
    `CHK("shifter_clock_in", v[2], sck)
    `CHK("shifter_serial_in", v[0], sdi)
  endtask

  // Each steering bit on its own pin, gated by direction
  task automatic t_timer;
    for (int i = 0; i < 8; i++)
    begin
      idle();
      {cha, chb, dir} = {1'b1, 1'b1, 8'h01 << i};
      steer = 8'h01 << (i[0] ? 4 + i / 2 : i / 2);
      settle();
      `CHK("pin_oe", 8'h01 << i, pin_oe)
      `CHK("pin_out", 8'h01 << i, pin_out)
      dir = 8'h00;
      settle();
      `CHK("pin_oe", 8'h00, pin_oe)
    end
  endtask

  // Plain port bits, bit 7 included, pull-up and its disable
  task automatic t_plain;
    idle();
    {dir, data, ext_en, ext_val} = {8'h8f, 8'hb3, 8'h70, 8'h20};
    settle();
    `CHK("pin_oe", 8'h8f, pin_oe)
    `CHK("pin_out", 8'h83, pin_out & 8'h8f)
    `CHK("pin_pullup", 8'h30, pin_pu)
    `CHK("read_dir", 8'h8f, r_dir)
    `CHK("read_data", 8'hb3, r_data)
    `CHK("read_pin", 8'ha3, r_pin)
    puoff = 1'b1;
    settle();
    `CHK("pin_pullup", 8'h00, pin_pu)
  endtask

  // Bit 7 as reset input, then as open-drain debug line
  task automatic t_reset_pin;
    idle();
    {rfuse, dir, data, ext_val} = {1'b0, 8'hff, 8'hff, 8'hff};
    settle();
    `CHK("pin_oe7", 1'b0, pin_oe[7])
    `CHK("readback7", 3'b000, {r_dir[7], r_data[7], r_pin[7]})
    `CHK("reset_request", 1'b0, rreq)
    `CHK("pin_change_src_15", 1'b0, pcs[15])
    ext_val = 8'h7f;
    settle();
    `CHK("reset_request", 1'b1, rreq)
    {dfuse, dlow, ext_en} = {1'b1, 1'b1, 8'h7f};
    settle();
    `CHK("debug_drive", 2'b10, {pin_oe[7], pin_out[7]})
    dlow = 1'b0;
    settle();
    `CHK("debug_release", 2'b01, {pin_oe[7], pin_pu[7]})
    `CHK("debug_line_in", 1'b1, dbg)
    {lock, dlow} = 2'b11;
    settle();
    `CHK("locked_oe7", 1'b0, pin_oe[7])
  endtask

  // Clock output on bit 5, crystal pins block I/O
  task automatic t_clocks;
    idle();
    {cfuse, dclk} = 2'b11;
    settle();
    `CHK("clkout_hi", 2'b11, {pin_oe[5], pin_out[5]})
    {dclk, dir, data} = {1'b0, 8'h20, 8'h20};
    settle();
    `CHK("clkout_lo", 2'b10, {pin_oe[5], pin_out[5]})
    {osc2, osc1, steer, cha} = {1'b1, 1'b1, 8'h04, 1'b1};
    dir = 8'h30;
    data = 8'h30;
    settle();
    `CHK("pin_oe", 8'h00, pin_oe)
    `CHK("readback4", 3'b000, {r_dir[4], r_data[4], r_pin[4]})
  endtask

  // Shifter data out on bit 1, two-wire clock forced low
  task automatic t_shifter;
    idle();
    {w3, sdo, dir} = {1'b1, 1'b1, 8'h02};
    settle();
    `CHK("dout_hi", 2'b11, {pin_oe[1], pin_out[1]})
    sdo = 1'b0;
    settle();
    `CHK("dout_lo", 2'b10, {pin_oe[1], pin_out[1]})
    {dir, data} = {8'h00, 8'h02};
    settle();
    `CHK("dout_pullup", 2'b01, {pin_oe[1], pin_pu[1]})
    {w3, w2, hold, dir, data} = {3'b011, 8'h05, 8'h00};
    {steer, cha} = {8'h02, 1'b1};
    settle();
    `CHK("scl_low", 2'b10, {pin_oe[2], pin_out[2]})
    `CHK("sda_low", 2'b10, {pin_oe[0], pin_out[0]})
    {hold, sdo} = 2'b01;
    settle();
    `CHK("scl_oe", 1'b0, pin_oe[2])
    `CHK("sda_release", 1'b0, pin_oe[0])
    pos = 1'b1;
    settle();
    `CHK("alt_pos_b2", 2'b11, {pin_oe[2], pin_out[2]})
  endtask

  // Clock enable low freezes every output
  task automatic t_freeze;
    idle();
    settle();
    {en, dir} = {1'b0, 8'hff};
    settle();
    `CHK("read_dir", 8'h00, r_dir)
    en = 1'b1;
    settle();
    `CHK("read_dir", 8'hff, r_dir)
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    idle();
    rst = 1'b1;
    t_reset();
    t_inputs(8'ha5);
    t_inputs(8'h5a);
    t_timer();
    t_plain();
    t_reset_pin();
    t_reset();
    t_clocks();
    t_shifter();
    t_freeze();
    conclude();
  end
endmodule
